// ===== core/wrp_core.sv
// Purpose: Executes working-register page instructions on acc and memory.
// Assumes: Whole instruction offered at once; register port never waits.
// Notes: Register writes act only while idle and not taking an instruction.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module wrp_core (
    input wire logic i_sys_clk, // Core clock
    input wire logic i_nrst, // Reset, active low, asynchronous
    input wire logic [2:0] i_reg_addr, // Register index
    input wire logic [7:0] i_reg_wdata, // Register write data
    input wire logic i_reg_wr, // Write strobe
    input wire logic i_reg_rd, // Read strobe
    output logic [7:0] o_reg_rdata, // Read data, cycle after strobe
    input wire logic i_ins_valid, // Instruction offered
    input wire logic [7:0] i_ins_byte0, // First instruction byte
    input wire logic [7:0] i_ins_byte1, // Second instruction byte
    input wire logic [7:0] i_ins_byte2, // Third instruction byte
    output logic o_ins_ready, // Sequencer idle, takes instruction
    output logic o_ins_done, // Instruction finished, pulse
    output logic o_ins_skipped, // Instruction suppressed, pulse
    output logic o_busy // Instruction in progress
);
    import wrp_pkg::*;

    // ==========================================================
    // State record
    typedef struct packed {
        wrp_st_e st;
        wrp_op_e op;
        logic [4:0] cnt;
        logic [7:0] off;
        logic [7:0] imm;
        logic [7:0] page;
        logic [7:0] acc;
        logic [5:0] flags;
        logic [15:0] maddr;
        logic [7:0] rdata;
        logic rsel_mem;
        logic unknown;
        logic done;
        logic skipped;
    } wrp_state_s;

    wrp_state_s q;
    wrp_state_s d;
    logic rst_meta_q;
    logic rst_n;
    logic accept;
    logic go;
    wrp_op_e dec;
    logic [7:0] alu_x;
    logic [7:0] alu_y;
    logic [7:0] alu_res;
    logic alu_zero;
    logic alu_borrow;
    logic alu_half;
    logic alu_skip;

    wrp_mem_if mem_if ();

    // ==========================================================
    // Reset release through two flops
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // ==========================================================
    // Submodules
    wrp_page_mem u_mem (
        .i_clk(i_sys_clk),
        .i_rst_n(rst_n),
        .mem_if(mem_if.mem)
    );

    // Immediate ops work on memory, accumulator ops on acc
    assign alu_x = wrp_is_imm(q.op) ? mem_if.rdata : q.acc;
    assign alu_y = wrp_is_imm(q.op) ? q.imm : mem_if.rdata;

    wrp_alu u_alu (
        .i_op(q.op),
        .i_x(alu_x),
        .i_y(alu_y),
        .o_res(alu_res),
        .o_zero(alu_zero),
        .o_borrow(alu_borrow),
        .o_half(alu_half),
        .o_skip(alu_skip)
    );

    // ==========================================================
    // Memory port steering
    always_comb begin
        if (q.st == WRP_IDLE) begin
            mem_if.addr = q.maddr;
            mem_if.wdata = i_reg_wdata;
            mem_if.we = i_reg_wr && !accept && (i_reg_addr == WRP_RA_MDATA);
        end else begin
            mem_if.addr = {q.page, q.off};
            mem_if.wdata = alu_res;
            mem_if.we = (q.st == WRP_EX) && (q.op == WRP_OP_AND_I || q.op == WRP_OP_OR_I);
        end
    end

    // ==========================================================
    // Sequencer and register file
    assign dec = wrp_decode(i_ins_byte0, i_ins_byte1);
    assign accept = i_ins_valid && (q.st == WRP_IDLE);
    assign go = accept && !q.flags[WRP_FB_BYPASS] && (dec != WRP_OP_NONE);

    always_comb begin
        d = q;
        d.done = 1'b0;
        d.skipped = 1'b0;
        d.rsel_mem = 1'b0;
        d.rdata = 8'h00;
        case (q.st)
            WRP_IDLE: begin
                if (accept) begin
                    if (q.flags[WRP_FB_BYPASS]) begin
                        // Drop the instruction whole, then run normally
                        d.flags[WRP_FB_BYPASS] = 1'b0;
                        d.skipped = 1'b1;
                        d.done = 1'b1;
                    end else if (dec == WRP_OP_NONE) begin
                        d.unknown = 1'b1;
                        d.done = 1'b1;
                    end else begin
                        d.unknown = 1'b0;
                        d.op = dec;
                        // Offset sits in byte 2 for acc ops, byte 1 for imm ops
                        d.off = wrp_is_imm(dec) ? i_ins_byte1 : i_ins_byte2;
                        d.imm = i_ins_byte2;
                        d.cnt = 5'h01;
                        d.st = WRP_RD;
                    end
                end else if (i_reg_wr) begin
                    case (i_reg_addr)
                        WRP_RA_ACC: d.acc = i_reg_wdata;
                        WRP_RA_PAGE: d.page = i_reg_wdata;
                        WRP_RA_FLAGS: d.flags = i_reg_wdata[5:0];
                        WRP_RA_MADDR_LO: d.maddr[7:0] = i_reg_wdata;
                        WRP_RA_MADDR_HI: d.maddr[15:8] = i_reg_wdata;
                        default: d.flags = q.flags;
                    endcase
                end
            end
            WRP_RD: begin
                d.cnt = q.cnt + 5'h01;
                d.st = WRP_EX;
            end
            WRP_EX: begin
                d.cnt = q.cnt + 5'h01;
                d.st = WRP_WT;
                d.flags[WRP_FB_NULL] = alu_zero;
                d.flags[WRP_FB_L1] = 1'b0;
                d.flags[WRP_FB_L0] = 1'b0;
                d.flags[WRP_FB_BYPASS] = alu_skip;
                if (wrp_is_sub(q.op)) begin
                    d.flags[WRP_FB_HC] = alu_half;
                    d.flags[WRP_FB_CY] = alu_borrow;
                end
                // Only the acc logic ops store into acc; tests, compares and immediate logic ops keep it
                if (q.op == WRP_OP_AND_A || q.op == WRP_OP_OR_A || q.op == WRP_OP_XOR_A) begin
                    d.acc = alu_res;
                end
            end
            WRP_WT: begin
                if (q.cnt == wrp_states(q.op) - 5'h01) begin
                    d.st = WRP_IDLE;
                    d.done = 1'b1;
                end else begin
                    d.cnt = q.cnt + 5'h01;
                end
            end
            default: d.st = WRP_IDLE;
        endcase
        // Register reads show the value before any same-cycle write
        if (i_reg_rd) begin
            case (i_reg_addr)
                WRP_RA_ACC: d.rdata = q.acc;
                WRP_RA_PAGE: d.rdata = q.page;
                WRP_RA_FLAGS: d.rdata = {2'b00, q.flags};
                WRP_RA_MADDR_LO: d.rdata = q.maddr[7:0];
                WRP_RA_MADDR_HI: d.rdata = q.maddr[15:8];
                WRP_RA_MDATA: d.rsel_mem = 1'b1;
                WRP_RA_STAT: d.rdata = {6'h00, q.unknown, q.st != WRP_IDLE};
                default: d.rdata = 8'h00;
            endcase
        end
    end

    // State register
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    assign o_reg_rdata = q.rsel_mem ? mem_if.rdata : q.rdata;
    assign o_ins_ready = (q.st == WRP_IDLE);
    assign o_ins_done = q.done;
    assign o_ins_skipped = q.skipped;
    assign o_busy = (q.st != WRP_IDLE);

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!rst_n);

    // Operand fetch, instruction length and unknown codes
    // Offset is byte 2 for acc ops, byte 1 for imm ops; page must not move
    a_addr_concat: assert property ((go && !wrp_is_imm(dec)) |=>
        mem_if.addr == {$past(q.page), $past(i_ins_byte2)})
        else $error("operand address not page base and offset");

    a_imm_offset: assert property ((go && wrp_is_imm(dec)) |=>
        mem_if.addr == {$past(q.page), $past(i_ins_byte1)})
        else $error("immediate op offset not from byte 1");

    // Counted from the take edge; done is sampled one edge after it is set
    a_acc_len: assert property ((go && wrp_states(dec) == WRP_CNT_ACC) |->
        !o_ins_done [*8] ##7 o_ins_done)
        else $error("acc page op did not finish in 14 cycles");

    a_rmw_len: assert property ((go && wrp_states(dec) == WRP_CNT_RMW) |->
        ##19 o_ins_done)
        else $error("read-modify-write op did not finish in 19 cycles");

    a_cmpi_len: assert property ((go && wrp_states(dec) == WRP_CNT_CMPI) |->
        ##12 !o_ins_done ##1 o_ins_done)
        else $error("immediate compare did not finish in 13 cycles");

    a_unknown_keep: assert property ((accept && dec == WRP_OP_NONE) |=>
        o_ins_done && o_ins_ready && $stable(q.acc))
        else $error("unknown instruction changed state");

    // Results stored into acc or written back to the page
    a_and_result: assert property ((q.st == WRP_EX && q.op == WRP_OP_AND_A) |=>
        q.acc == ($past(q.acc) & $past(mem_if.rdata)) && !q.flags[WRP_FB_BYPASS])
        else $error("and into acc wrong");

    a_or_result: assert property ((q.st == WRP_EX && q.op == WRP_OP_OR_A) |=>
        q.acc == ($past(q.acc) | $past(mem_if.rdata)))
        else $error("or into acc wrong");

    a_xor_result: assert property ((q.st == WRP_EX && q.op == WRP_OP_XOR_A) |=>
        q.acc == ($past(q.acc) ^ $past(mem_if.rdata)) && !q.flags[WRP_FB_BYPASS])
        else $error("xor into acc wrong");

    a_and_write: assert property ((q.st == WRP_EX && q.op == WRP_OP_AND_I) |->
        mem_if.we && mem_if.wdata == (mem_if.rdata & q.imm))
        else $error("and immediate write back wrong");

    a_rmw_write: assert property ((q.st == WRP_EX && q.op == WRP_OP_OR_I) |->
        mem_if.we && mem_if.wdata == (mem_if.rdata | q.imm))
        else $error("or immediate write back wrong");

    // Skip decisions; a met skip must land in bypass
    a_gt_skip: assert property ((q.st == WRP_EX && q.op == WRP_OP_GT_A) |=>
        q.flags[WRP_FB_BYPASS] == ($past(q.acc) > $past(mem_if.rdata)))
        else $error("greater compare skip wrong");

    a_eq_skip: assert property ((q.st == WRP_EX && q.op == WRP_OP_EQ_A) |=>
        q.flags[WRP_FB_BYPASS] == ($past(q.acc) == $past(mem_if.rdata)))
        else $error("equal compare skip wrong");

    a_off_skip: assert property ((q.st == WRP_EX && q.op == WRP_OP_OFF_A) |=>
        q.flags[WRP_FB_BYPASS] == (($past(q.acc) & $past(mem_if.rdata)) == 8'h00))
        else $error("off test skip wrong");

    a_gt_imm_skip: assert property ((q.st == WRP_EX && q.op == WRP_OP_GT_I) |=>
        q.flags[WRP_FB_BYPASS] == ($past(mem_if.rdata) > $past(q.imm)))
        else $error("greater immediate skip wrong");

    a_lt_skip: assert property ((q.st == WRP_EX && q.op == WRP_OP_LT_I) |=>
        q.flags[WRP_FB_BYPASS] == ($past(mem_if.rdata) < $past(q.imm)))
        else $error("less immediate skip wrong");

    a_ne_imm_skip: assert property ((q.st == WRP_EX && q.op == WRP_OP_NE_I) |=>
        q.flags[WRP_FB_BYPASS] == ($past(mem_if.rdata) != $past(q.imm)))
        else $error("unequal immediate skip wrong");

    a_on_imm_skip: assert property ((q.st == WRP_EX && q.op == WRP_OP_ON_I) |=>
        q.flags[WRP_FB_BYPASS] == (($past(mem_if.rdata) & $past(q.imm)) != 8'h00))
        else $error("on test immediate skip wrong");

    // Flag side effects and suppression of the next instruction
    a_test_keep: assert property ((q.st == WRP_EX && wrp_is_test(q.op)) |=>
        $stable(q.acc) && $stable(q.flags[WRP_FB_CY]) && $stable(q.flags[WRP_FB_HC])
        && !q.flags[WRP_FB_L1])
        else $error("bit test changed acc or carries");

    a_load_clear: assert property ((q.st == WRP_EX) |=>
        !q.flags[WRP_FB_L1] && !q.flags[WRP_FB_L0])
        else $error("load chain flags not cleared");

    a_skip_supp: assert property ((accept && q.flags[WRP_FB_BYPASS]) |=>
        o_ins_skipped && o_ins_ready && $stable(q.acc) && !q.flags[WRP_FB_BYPASS])
        else $error("bypassed instruction not suppressed");

    // Coverage of the main scenarios
    c_skip_taken: cover property (accept && q.flags[WRP_FB_BYPASS]);
    c_rmw_done: cover property ((q.st == WRP_WT && q.op == WRP_OP_AND_I) ##1 o_ins_done);
    c_eq_skip: cover property (q.st == WRP_EX && q.op == WRP_OP_EQ_A && alu_skip);
    c_gt_imm_skip: cover property (q.st == WRP_EX && q.op == WRP_OP_GT_I && alu_skip);
    c_unknown: cover property (accept && dec == WRP_OP_NONE);
endmodule
`default_nettype wire

// ===== core/wrp_pkg.sv
// Purpose: Shared constants, types and decode helpers for the page ops.
// Assumes: One core clock; state counts equal clock cycles.
// Notes: Opcode values kept here only.
package wrp_pkg;
    // ==========================================================
    // Widths and encodings
    localparam int WRP_AW = 16;
    localparam logic [7:0] WRP_PREFIX = 8'h74;
    localparam logic [7:0] WRP_OPC_AND_A = 8'h88;
    localparam logic [7:0] WRP_OPC_OR_A = 8'h98;
    localparam logic [7:0] WRP_OPC_XOR_A = 8'h90;
    localparam logic [7:0] WRP_OPC_GT_A = 8'ha8;
    localparam logic [7:0] WRP_OPC_LT_A = 8'hb8;
    localparam logic [7:0] WRP_OPC_NE_A = 8'he8;
    localparam logic [7:0] WRP_OPC_EQ_A = 8'hf8;
    localparam logic [7:0] WRP_OPC_ON_A = 8'hc8;
    localparam logic [7:0] WRP_OPC_OFF_A = 8'hd8;
    localparam logic [7:0] WRP_OPC_AND_I = 8'h05;
    localparam logic [7:0] WRP_OPC_OR_I = 8'h15;
    localparam logic [7:0] WRP_OPC_GT_I = 8'h25;
    localparam logic [7:0] WRP_OPC_LT_I = 8'h35;
    localparam logic [7:0] WRP_OPC_ON_I = 8'h45;
    localparam logic [7:0] WRP_OPC_NE_I = 8'h65;
    localparam logic [7:0] WRP_OPC_EQ_I = 8'h75;
    // ==========================================================
    // Cycle counts per instruction class
    localparam logic [4:0] WRP_CNT_ACC = 5'h0e;
    localparam logic [4:0] WRP_CNT_RMW = 5'h13;
    localparam logic [4:0] WRP_CNT_CMPI = 5'h0d;
    // ==========================================================
    // Register port map and flag bit positions
    localparam logic [2:0] WRP_RA_ACC = 3'h0;
    localparam logic [2:0] WRP_RA_PAGE = 3'h1;
    localparam logic [2:0] WRP_RA_FLAGS = 3'h2;
    localparam logic [2:0] WRP_RA_MADDR_LO = 3'h3;
    localparam logic [2:0] WRP_RA_MADDR_HI = 3'h4;
    localparam logic [2:0] WRP_RA_MDATA = 3'h5;
    localparam logic [2:0] WRP_RA_STAT = 3'h6;
    localparam int WRP_FB_NULL = 0;
    localparam int WRP_FB_BYPASS = 1;
    localparam int WRP_FB_HC = 2;
    localparam int WRP_FB_L1 = 3;
    localparam int WRP_FB_L0 = 4;
    localparam int WRP_FB_CY = 5;
    // ==========================================================
    // Operation and sequencer types
    typedef enum logic [4:0] {
        WRP_OP_NONE = 5'b00000, WRP_OP_AND_A = 5'b00001, WRP_OP_OR_A = 5'b00010,
        WRP_OP_XOR_A = 5'b00011, WRP_OP_GT_A = 5'b00100, WRP_OP_LT_A = 5'b00101,
        WRP_OP_NE_A = 5'b00110, WRP_OP_EQ_A = 5'b00111, WRP_OP_ON_A = 5'b01000,
        WRP_OP_OFF_A = 5'b01001, WRP_OP_AND_I = 5'b01010, WRP_OP_OR_I = 5'b01011,
        WRP_OP_GT_I = 5'b01100, WRP_OP_LT_I = 5'b01101, WRP_OP_NE_I = 5'b01110,
        WRP_OP_EQ_I = 5'b01111, WRP_OP_ON_I = 5'b10000
    } wrp_op_e;
    typedef enum logic [1:0] {
        WRP_IDLE = 2'b00, WRP_RD = 2'b01, WRP_EX = 2'b10, WRP_WT = 2'b11
    } wrp_st_e;
    // ==========================================================
    // Decode helpers
    function automatic wrp_op_e wrp_decode(input logic [7:0] b0, input logic [7:0] b1);
        wrp_decode = WRP_OP_NONE;
        if (b0 == WRP_PREFIX) begin
            case (b1)
                WRP_OPC_AND_A: wrp_decode = WRP_OP_AND_A;
                WRP_OPC_OR_A: wrp_decode = WRP_OP_OR_A;
                WRP_OPC_XOR_A: wrp_decode = WRP_OP_XOR_A;
                WRP_OPC_GT_A: wrp_decode = WRP_OP_GT_A;
                WRP_OPC_LT_A: wrp_decode = WRP_OP_LT_A;
                WRP_OPC_NE_A: wrp_decode = WRP_OP_NE_A;
                WRP_OPC_EQ_A: wrp_decode = WRP_OP_EQ_A;
                WRP_OPC_ON_A: wrp_decode = WRP_OP_ON_A;
                WRP_OPC_OFF_A: wrp_decode = WRP_OP_OFF_A;
                default: wrp_decode = WRP_OP_NONE;
            endcase
        end else begin
            case (b0)
                WRP_OPC_AND_I: wrp_decode = WRP_OP_AND_I;
                WRP_OPC_OR_I: wrp_decode = WRP_OP_OR_I;
                WRP_OPC_GT_I: wrp_decode = WRP_OP_GT_I;
                WRP_OPC_LT_I: wrp_decode = WRP_OP_LT_I;
                WRP_OPC_NE_I: wrp_decode = WRP_OP_NE_I;
                WRP_OPC_EQ_I: wrp_decode = WRP_OP_EQ_I;
                WRP_OPC_ON_I: wrp_decode = WRP_OP_ON_I;
                default: wrp_decode = WRP_OP_NONE;
            endcase
        end
    endfunction
    function automatic logic wrp_is_imm(input wrp_op_e op);
        return op >= WRP_OP_AND_I;
    endfunction
    function automatic logic wrp_is_sub(input wrp_op_e op);
        return (op >= WRP_OP_GT_A && op <= WRP_OP_EQ_A)
            || (op >= WRP_OP_GT_I && op <= WRP_OP_EQ_I);
    endfunction
    function automatic logic wrp_is_test(input wrp_op_e op);
        return op == WRP_OP_ON_A || op == WRP_OP_OFF_A || op == WRP_OP_ON_I;
    endfunction
    function automatic logic [4:0] wrp_states(input wrp_op_e op);
        if (op == WRP_OP_AND_I || op == WRP_OP_OR_I) begin
            return WRP_CNT_RMW;
        end
        return wrp_is_imm(op) ? WRP_CNT_CMPI : WRP_CNT_ACC;
    endfunction
endpackage

// ===== core/wrp_mem_if.sv
// Purpose: Port bundle between the sequencer and the page memory.
// Assumes: Read data arrive one clock after the address.
// Notes: Writes take effect at the clock edge.
`timescale 1ns/1ps
`default_nettype none
interface wrp_mem_if;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic [7:0] rdata;
    modport ctrl (output addr, output wdata, output we, input rdata);
    modport mem (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// ===== core/wrp_page_mem.sv
// Purpose: Working register storage, one byte per address.
// Assumes: Single port, registered read, old data on read during write.
// Notes: Contents are not cleared by reset.
`timescale 1ns/1ps
`default_nettype none
module wrp_page_mem (
    input wire logic i_clk, // Core clock
    input wire logic i_rst_n, // Synchronised reset, active low
    wrp_mem_if.mem mem_if // Address, write and read data
);
    import wrp_pkg::*;
    logic [7:0] ram [0:(1 << WRP_AW) - 1];
    logic [7:0] rdata_q;
    // ==========================================================
    // Storage write
    always_ff @(posedge i_clk) begin
        if (mem_if.we) begin
            ram[mem_if.addr] <= mem_if.wdata;
        end
    end
    // Registered read port
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= ram[mem_if.addr];
        end
    end
    assign mem_if.rdata = rdata_q;
endmodule
`default_nettype wire

// ===== core/wrp_alu.sv
// Purpose: Logic, compare and test arithmetic for the page ops.
// Assumes: Left operand x, right operand y, pure combinational.
// Notes: Borrow and half borrow follow an 8-bit subtract.
`timescale 1ns/1ps
`default_nettype none
module wrp_alu (
    input var wrp_pkg::wrp_op_e i_op, // Decoded operation
    input wire logic [7:0] i_x, // Left operand
    input wire logic [7:0] i_y, // Right operand
    output logic [7:0] o_res, // Result byte
    output logic o_zero, // Result is zero
    output logic o_borrow, // Borrow out of bit 7
    output logic o_half, // Borrow out of bit 3
    output logic o_skip // Skip condition met
);
    import wrp_pkg::*;
    logic one;
    logic [8:0] diff;
    logic [4:0] hdiff;
    // ==========================================================
    // Result and condition
    always_comb begin
        one = (i_op == WRP_OP_GT_A) || (i_op == WRP_OP_GT_I);
        diff = {1'b0, i_x} - {1'b0, i_y} - {8'h00, one};
        hdiff = {1'b0, i_x[3:0]} - {1'b0, i_y[3:0]} - {4'h0, one};
        case (i_op)
            WRP_OP_OR_A, WRP_OP_OR_I: o_res = i_x | i_y;
            WRP_OP_XOR_A: o_res = i_x ^ i_y;
            default: o_res = wrp_is_sub(i_op) ? diff[7:0] : (i_x & i_y);
        endcase
        o_zero = (o_res == 8'h00);
        o_borrow = diff[8];
        o_half = hdiff[4];
        case (i_op)
            WRP_OP_GT_A, WRP_OP_GT_I: o_skip = !diff[8];
            WRP_OP_LT_A, WRP_OP_LT_I: o_skip = diff[8];
            WRP_OP_NE_A, WRP_OP_NE_I: o_skip = !o_zero;
            WRP_OP_EQ_A, WRP_OP_EQ_I: o_skip = o_zero;
            WRP_OP_ON_A, WRP_OP_ON_I: o_skip = !o_zero;
            WRP_OP_OFF_A: o_skip = o_zero;
            default: o_skip = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// ===== dv/wrp_core_tb_top.sv
// Purpose: Self-checking bench for the working register page op core.
// Assumes: Page memory is loaded and read back through the register port.
// Notes: Expected values come from a small reference model in this bench.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin mismatches++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module wrp_core_tb_top;
    import wrp_pkg::*;
    // ==========================================================
    // Stimulus state, tables and counters
    logic i_sys_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wd = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic iv = 1'b0;
    logic [7:0] b0 = 8'h00, b1 = 8'h00, b2 = 8'h00;
    logic [7:0] o_reg_rdata;
    logic o_ins_ready, o_ins_done, o_ins_skipped, o_busy;
    int mismatches = 0;
    int n_checks = 0;
    logic [7:0] efl = 8'h00, acc = 8'h00, m = 8'h0f, rv, r;
    int k;
    localparam logic [7:0] OPA [9] = '{WRP_OPC_AND_A, WRP_OPC_OR_A, WRP_OPC_XOR_A,
        WRP_OPC_GT_A, WRP_OPC_LT_A, WRP_OPC_NE_A, WRP_OPC_EQ_A, WRP_OPC_ON_A, WRP_OPC_OFF_A};
    localparam logic [7:0] ACCS [9] = '{8'h1f, 8'hf0, 8'h0f, 8'h0f, 8'h0e, 8'h0f, 8'h0f,
        8'hf0, 8'hf0};
    localparam logic [7:0] OPI [7] = '{WRP_OPC_AND_I, WRP_OPC_OR_I, WRP_OPC_GT_I,
        WRP_OPC_LT_I, WRP_OPC_NE_I, WRP_OPC_EQ_I, WRP_OPC_ON_I};
    localparam int KI [7] = '{0, 1, 3, 4, 5, 6, 7};
    localparam logic [7:0] IMM [7] = '{8'h3c, 8'h30, 8'h3b, 8'h3c, 8'h3c, 8'h3c, 8'hc3};
    // Free running core clock, 20 ns period
    always #10 i_sys_clk = ~i_sys_clk;
    wrp_core i_wrp_core (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_reg_addr(addr),
        .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(o_reg_rdata),
        .i_ins_valid(iv), .i_ins_byte0(b0), .i_ins_byte1(b1), .i_ins_byte2(b2),
        .o_ins_ready(o_ins_ready), .o_ins_done(o_ins_done), .o_ins_skipped(o_ins_skipped),
        .o_busy(o_busy));
    // ==========================================================
    // Reference model: kinds and, or, xor, gt, lt, ne, eq, on, off
    function automatic logic [7:0] model(input int kd, input logic [7:0] x, input logic [7:0] y);
        logic [8:0] d;
        logic [4:0] h;
        logic [7:0] q;
        logic s;
        d = {1'b0, x} - {1'b0, y} - 9'(kd == 3);
        h = {1'b0, x[3:0]} - {1'b0, y[3:0]} - 5'(kd == 3);
        q = (kd == 0 || kd >= 7) ? (x & y) : (kd == 1) ? (x | y) : (kd == 2) ? (x ^ y) : d[7:0];
        s = (kd == 3) ? !d[8] : (kd == 4) ? d[8] : (kd == 5 || kd == 7) ? (q != 8'h00) :
            (kd == 6 || kd == 8) ? (q == 8'h00) : 1'b0;
        efl[0] = (q == 8'h00);
        efl[1] = s;
        efl[3] = 1'b0;
        efl[4] = 1'b0;
        if (kd >= 3 && kd <= 6) begin
            efl[2] = h[4];
            efl[5] = d[8];
        end
        return q;
    endfunction
    // ==========================================================
    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Register port cycles, one strobe each
    task automatic reg_wr(input logic [2:0] ad, input logic [7:0] d);
        @(posedge i_sys_clk);
        addr <= ad;
        wd <= d;
        wr <= 1'b1;
        @(posedge i_sys_clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [2:0] ad, output logic [7:0] d);
        @(posedge i_sys_clk);
        addr <= ad;
        rd <= 1'b1;
        @(posedge i_sys_clk);
        rd <= 1'b0;
        #1 d = o_reg_rdata;
    endtask
    task automatic mem_sel(input logic [15:0] ma);
        reg_wr(WRP_RA_MADDR_LO, ma[7:0]);
        reg_wr(WRP_RA_MADDR_HI, ma[15:8]);
    endtask
    // Offer one instruction, count cycles to done under a bound
    task automatic exec(input logic [7:0] x0, x1, x2, input int n_exp, input logic sk_exp);
        int n;
        @(posedge i_sys_clk);
        iv <= 1'b1;
        b0 <= x0;
        b1 <= x1;
        b2 <= x2;
        @(posedge i_sys_clk);
        iv <= 1'b0;
        // Look right after the take edge: a dropped instruction is done there
        for (n = 1; n < 40; n++) begin
            #1;
            if (n == 1) `CHK("busy after take", n_exp > 1, o_busy)
            if (o_ins_done === 1'b1) break;
            @(posedge i_sys_clk);
        end
        `CHK("cycles", n_exp, n)
        `CHK("ready at done", 1'b1, o_ins_ready)
        `CHK("skipped", sk_exp, o_ins_skipped)
        if (n >= 40) close_out();
    endtask
    // After a met skip the next instruction must be dropped whole
    task automatic skip_check();
        if (efl[1]) begin
            exec(WRP_PREFIX, WRP_OPC_XOR_A, 8'h33, 1, 1'b1);
            efl[1] = 1'b0;
            reg_rd(WRP_RA_ACC, rv);
            `CHK("acc after skip", acc, rv)
            reg_rd(WRP_RA_FLAGS, rv);
            `CHK("flags after skip", efl, rv)
        end
    endtask
    // ==========================================================
    // Scenarios
    task automatic scen_reset();
        reg_rd(WRP_RA_FLAGS, rv);
        `CHK("flags at reset", 8'h00, rv)
        reg_rd(3'h7, rv);
        `CHK("unmapped read", 8'h00, rv)
        mem_sel(16'h0033);
        reg_wr(WRP_RA_MDATA, 8'hff);
        mem_sel(16'h5a33);
        reg_wr(WRP_RA_MDATA, m);
        reg_wr(WRP_RA_PAGE, 8'h5a);
    endtask
    task automatic scen_acc_ops();
        for (k = 0; k < 9; k++) begin
            reg_wr(WRP_RA_ACC, ACCS[k]);
            acc = ACCS[k];
            r = model(k, acc, m);
            if (k < 3) acc = r;
            exec(WRP_PREFIX, OPA[k], 8'h33, 14, 1'b0);
            reg_rd(WRP_RA_ACC, rv);
            `CHK("acc", acc, rv)
            reg_rd(WRP_RA_FLAGS, rv);
            `CHK("flags", efl, rv)
            skip_check();
        end
    endtask
    task automatic scen_imm_ops();
        for (k = 0; k < 7; k++) begin
            r = model(KI[k], m, IMM[k]);
            exec(OPI[k], 8'h33, IMM[k], (k < 2) ? 19 : 13, 1'b0);
            if (k < 2) m = r;
            mem_sel(16'h5a33);
            reg_rd(WRP_RA_MDATA, rv);
            `CHK("page byte", m, rv)
            reg_rd(WRP_RA_FLAGS, rv);
            `CHK("flags", efl, rv)
            skip_check();
        end
        mem_sel(16'h0033);
        reg_rd(WRP_RA_MDATA, rv);
        `CHK("other page byte", 8'hff, rv)
    endtask
    task automatic scen_unknown();
        exec(WRP_PREFIX, 8'h00, 8'h33, 1, 1'b0);
        reg_rd(WRP_RA_ACC, rv);
        `CHK("acc after unknown", acc, rv)
        reg_rd(WRP_RA_STAT, rv);
        `CHK("stat after unknown", 8'h02, rv)
    endtask
    // Main sequence: reset for 8 cycles, then scenarios
    initial begin
        repeat (8) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        scen_reset();
        scen_acc_ops();
        scen_imm_ops();
        scen_unknown();
        close_out();
    end
endmodule
`undef CHK
`default_nettype wire
